// ==== design/imx_defines.svh ====
// Constants for the indirect store / misc execute block.
// Assumes inclusion by the package and the design module only.
`ifndef IMX_DEFINES_SVH
`define IMX_DEFINES_SVH
`define IMX_MODE_PREINC     2'h0
`define IMX_MODE_PREDEC     2'h1
`define IMX_MODE_POSTINC    2'h2
`define IMX_MODE_POSTDEC    2'h3
`define IMX_PTR_RESET       16'h0000
`define IMX_OPTION_RESET    8'hFF
`define IMX_STATUS_RESET    8'h00
`define IMX_WORKING_RESET   8'h00
`define IMX_RI_FLAG_RESET   1'h1
`define IMX_PTR_ONE         16'h0001
`define IMX_RESET_PULSE_CYC 4'h2
`endif

// ==== design/imx_pkg.sv ====
// Types for the indirect store / misc execute block.
// Assumes the defines header sits beside it.
`include "imx_defines.svh"
package imx_pkg;
  typedef enum logic [2:0] {
    IMX_OP_NONE,
    IMX_OP_NOP,
    IMX_OP_STORE_MODE,
    IMX_OP_STORE_REL,
    IMX_OP_OPTION,
    IMX_OP_RESET
  } imx_op_e;
  typedef enum logic [0:0] {
    IMX_ST_RUN,
    IMX_ST_RESET
  } imx_state_e;
endpackage

// ==== design/imx_exec.sv ====
// Execute stage for indirect store, no-op, option load and software reset.
// Assumes decode presents one op per cycle with op_valid, on the core clock.
//
// Operation
// - Indirect store writes working value to memory through selected pointer.
// - Modes 00/01 adjust pointer by one before forming write address.
// - Modes 10/11 write at current pointer, then adjust it by one.
// - Indirect port has no storage; access goes to pointer's address.
// - Pointer is 16 bits and wraps modulo its range.
// - Pointer update by indirect store leaves all status flags unchanged.
// - Option load copies working value to option register in one cycle.
// - Software reset triggers device reset and clears reset-instruction flag.
`timescale 1ns/100ps
`include "imx_defines.svh"
module imx_exec
  import imx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        op_valid,
  input  imx_op_e          op_code,
  input  wire logic        ptr_select,
  input  wire logic [1:0]  pointer_mode_code,
  input  wire logic [5:0]  rel_offset,
  input  wire logic        working_load,
  input  wire logic [7:0]  working_data,
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_load_data,
  input  wire logic        status_load,
  input  wire logic [7:0]  status_data,
  input  wire logic        ri_flag_set,
  output logic             mem_wr,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             pc_advance,
  output logic [15:0]      file_select_pointer0,
  output logic [15:0]      file_select_pointer1,
  output logic [7:0]       option_reg,
  output logic [7:0]       status_reg,
  output logic [7:0]       working_reg,
  output logic             reset_instr_flag,
  output logic             device_reset_req
);

  // Two pointers only; the indirect port itself keeps no storage
  logic [15:0] ptr_reg [2];
  logic [15:0] ptr_next [2];
  logic        mem_wr_reg,  mem_wr_next;
  logic [15:0] addr_reg,    addr_next;
  logic [7:0]  wdata_reg,   wdata_next;
  logic        pc_reg,      pc_next;
  logic [7:0]  option_reg_q, option_next;
  logic [7:0]  status_reg_q, status_next;
  logic [7:0]  working_reg_q, working_next;
  logic        ri_reg,      ri_next;
  imx_state_e  state_reg,   state_next;
  logic [3:0]  cnt_reg,     cnt_next;
  logic        dev_rst_reg, dev_rst_next;

  // Shared pointer arithmetic, 16 bits wide so wrap comes for free
  logic [15:0] cur_ptr;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] rel_addr;
  logic        run_op;

  assign cur_ptr  = ptr_reg[ptr_select];
  assign ptr_inc  = cur_ptr + `IMX_PTR_ONE;
  assign ptr_dec  = cur_ptr - `IMX_PTR_ONE;
  // Sign extend 6-bit offset, wrap like the pointer
  assign rel_addr = cur_ptr + {{10{rel_offset[5]}}, rel_offset};
  // Ops are ignored while the software reset pulse runs
  assign run_op   = op_valid && (state_reg == IMX_ST_RUN);

  // Load inputs first so an executing op overrides them
  always_comb begin
    ptr_next[0]  = ptr_reg[0];
    ptr_next[1]  = ptr_reg[1];
    mem_wr_next  = 1'b0;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    pc_next      = 1'b0;
    option_next  = option_reg_q;
    status_next  = status_reg_q;
    working_next = working_reg_q;
    ri_next      = ri_reg;
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    dev_rst_next = 1'b0;
    if (ptr_load) begin
      ptr_next[ptr_select] = ptr_load_data;
    end
    if (status_load) begin
      status_next = status_data;
    end
    if (working_load) begin
      working_next = working_data;
    end
    if (ri_flag_set) begin
      ri_next = 1'b1;
    end
    // Pointer written by the op wins over a same-cycle ptr_load
    case (state_reg)
      IMX_ST_RUN: begin
        if (run_op) begin
          pc_next = 1'b1;
          case (op_code)
            IMX_OP_STORE_MODE: begin
              // No storage for the port: write lands at pointer address
              mem_wr_next = 1'b1;
              wdata_next  = working_reg_q;
              // Status untouched on all pointer updates
              case (pointer_mode_code)
                `IMX_MODE_PREINC: begin
                  addr_next            = ptr_inc;
                  ptr_next[ptr_select] = ptr_inc;
                end
                `IMX_MODE_PREDEC: begin
                  addr_next            = ptr_dec;
                  ptr_next[ptr_select] = ptr_dec;
                end
                `IMX_MODE_POSTINC: begin
                  addr_next            = cur_ptr;
                  ptr_next[ptr_select] = ptr_inc;
                end
                default: begin
                  addr_next            = cur_ptr;
                  ptr_next[ptr_select] = ptr_dec;
                end
              endcase
            end
            IMX_OP_STORE_REL: begin
              // Offset form never moves the pointer
              mem_wr_next = 1'b1;
              addr_next   = rel_addr;
              wdata_next  = working_reg_q;
            end
            IMX_OP_OPTION: begin
              option_next = working_reg_q;
            end
            IMX_OP_RESET: begin
              // Set from outside loses here: reset source must read as software
              ri_next      = 1'b0;
              dev_rst_next = 1'b1;
              cnt_next     = `IMX_RESET_PULSE_CYC;
              state_next   = IMX_ST_RESET;
              pc_next      = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      IMX_ST_RESET: begin
        // Core state returns to reset values; flag keeps its cleared value unless ri_flag_set sets it
        ptr_next[0]  = `IMX_PTR_RESET;
        ptr_next[1]  = `IMX_PTR_RESET;
        option_next  = `IMX_OPTION_RESET;
        status_next  = `IMX_STATUS_RESET;
        working_next = `IMX_WORKING_RESET;
        // Ops arriving here are dropped; no pc_advance during the window
        if (cnt_reg == 4'h1) begin
          state_next = IMX_ST_RUN;
        end else begin
          dev_rst_next = 1'b1;
          cnt_next     = cnt_reg - 4'h1;
        end
      end
      default: begin
        state_next = IMX_ST_RUN;
      end
    endcase
  end

  // Sync reset only; registers just take the next values
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg[0]    <= `IMX_PTR_RESET;
      ptr_reg[1]    <= `IMX_PTR_RESET;
      mem_wr_reg    <= 1'b0;
      addr_reg      <= `IMX_PTR_RESET;
      wdata_reg     <= 8'h00;
      pc_reg        <= 1'b0;
      option_reg_q  <= `IMX_OPTION_RESET;
      status_reg_q  <= `IMX_STATUS_RESET;
      working_reg_q <= `IMX_WORKING_RESET;
      ri_reg        <= `IMX_RI_FLAG_RESET;
      state_reg     <= IMX_ST_RUN;
      cnt_reg       <= 4'h0;
      dev_rst_reg   <= 1'b0;
    end else begin
      ptr_reg[0]    <= ptr_next[0];
      ptr_reg[1]    <= ptr_next[1];
      mem_wr_reg    <= mem_wr_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      pc_reg        <= pc_next;
      option_reg_q  <= option_next;
      status_reg_q  <= status_next;
      working_reg_q <= working_next;
      ri_reg        <= ri_next;
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      dev_rst_reg   <= dev_rst_next;
    end
  end

  // Every output comes straight from a flop, no decode after it
  assign mem_wr               = mem_wr_reg;
  assign mem_addr             = addr_reg;
  assign mem_wdata            = wdata_reg;
  assign pc_advance           = pc_reg;
  assign file_select_pointer0 = ptr_reg[0];
  assign file_select_pointer1 = ptr_reg[1];
  assign option_reg           = option_reg_q;
  assign status_reg           = status_reg_q;
  assign working_reg          = working_reg_q;
  assign reset_instr_flag     = ri_reg;
  assign device_reset_req     = dev_rst_reg;

endmodule // imx_exec

// ==== sim/imx_exec_checker.sv ====
// Port timing checks for imx_exec.
// Assumes the core clock and sync reset of the top module.
`timescale 1ns/100ps
module imx_chk
  import imx_pkg::*;
(
  input wire logic        clk, rst, op_valid, ptr_select, ptr_load, status_load,
  input imx_op_e          op_code,
  input wire logic [1:0]  pointer_mode_code,
  input wire logic [5:0]  rel_offset,
  input wire logic        mem_wr, pc_advance, reset_instr_flag, device_reset_req,
  input wire logic [15:0] mem_addr, file_select_pointer0, file_select_pointer1,
  input wire logic [7:0]  mem_wdata, option_reg, status_reg, working_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic go, sto;
  logic [15:0] cur, rel;
  // Ops in the reset window are refused
  assign go  = op_valid && !device_reset_req;
  assign sto = go && (op_code == IMX_OP_STORE_MODE || op_code == IMX_OP_STORE_REL);
  assign cur = ptr_select ? file_select_pointer1 : file_select_pointer0;
  assign rel = cur + {{10{rel_offset[5]}}, rel_offset};
  property p_pre;
    go && op_code == IMX_OP_STORE_MODE && pointer_mode_code == 2'h0
      |=> mem_wr && mem_addr == $past(cur) + 16'h0001;
  endproperty
  a_pre: assert property (p_pre) else $error("preinc address wrong");
  property p_post;
    go && op_code == IMX_OP_STORE_MODE && pointer_mode_code == 2'h3 |=> mem_addr == $past(cur);
  endproperty
  a_post: assert property (p_post) else $error("postdec address wrong");
  property p_pre_dec;
    go && op_code == IMX_OP_STORE_MODE && pointer_mode_code == 2'h1
      |=> mem_wr && mem_addr == $past(cur) - 16'h0001;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("predec address wrong");
  property p_post_inc;
    go && op_code == IMX_OP_STORE_MODE && pointer_mode_code == 2'h2 && !ptr_load
      |=> mem_addr == $past(cur) && cur == $past(cur) + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("postinc wrong");
  property p_data;
    sto |=> mem_wr && mem_wdata == $past(working_reg);
  endproperty
  a_data: assert property (p_data) else $error("store data wrong");
  property p_wr;
    mem_wr |-> $past(sto);
  endproperty
  a_wr: assert property (p_wr) else $error("write without store");
  property p_rel;
    go && op_code == IMX_OP_STORE_REL && !ptr_load
      |=> mem_addr == $past(rel) && cur == $past(cur);
  endproperty
  a_rel: assert property (p_rel) else $error("relative store wrong");
  property p_flags;
    go && op_code != IMX_OP_RESET && !status_load |=> $stable(status_reg);
  endproperty
  a_flags: assert property (p_flags) else $error("status changed");
  property p_opt;
    go && op_code == IMX_OP_OPTION |=> pc_advance && option_reg == $past(working_reg);
  endproperty
  a_opt: assert property (p_opt) else $error("option load wrong");
  property p_nop;
    go && op_code == IMX_OP_NOP |=> pc_advance && !mem_wr && $stable(option_reg);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");
  property p_rst;
    go && op_code == IMX_OP_RESET |=> !reset_instr_flag && device_reset_req && !pc_advance
      ##1 device_reset_req && option_reg == 8'hFF && !pc_advance ##1 !device_reset_req;
  endproperty
  a_rst: assert property (p_rst) else $error("software reset wrong");
  c_rst: cover property (go && op_code == IMX_OP_RESET);
  c_rel: cover property (go && op_code == IMX_OP_STORE_REL);
  c_wrap: cover property (mem_wr && mem_addr == 16'h0000);
endmodule // imx_chk
bind imx_exec imx_chk u_chk (.*);

// ==== sim/imx_mem_model.sv ====
// Data memory on the far side of imx_exec.
// Assumes one write pulse per store on the core clock.
`timescale 1ns/100ps
module imx_mem_model (
  input wire logic        clk,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata
);
  logic [7:0] mem [0:65535];
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule // imx_mem_model

// ==== sim/indirect_move_misc_exec_test.sv ====
// Self-checking bench for imx_exec.
// Assumes package, checker and memory model compiled first.
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", n, e, a); end end
module indirect_move_misc_exec_test;
  import imx_pkg::*;
  logic clk, rst, op_valid, ptr_select, working_load, ptr_load, status_load, ri_flag_set;
  imx_op_e op_code;
  logic [1:0] pointer_mode_code;
  logic [5:0] rel_offset;
  logic [7:0] working_data, status_data, mem_wdata, option_reg, status_reg, working_reg;
  logic [15:0] ptr_load_data, mem_addr, file_select_pointer0, file_select_pointer1, p, n;
  logic mem_wr, pc_advance, reset_instr_flag, device_reset_req;
  int fail_count = 0;
  int cmp_count = 0;
  imx_exec DUT (.*);
  imx_mem_model u_mem (.clk, .mem_wr, .mem_addr, .mem_wdata);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic load(input logic [7:0] w, input logic [15:0] ptr, input logic sel);
    @(posedge clk);
    working_load <= 1'b1; working_data <= w; ptr_load <= 1'b1; ptr_load_data <= ptr;
    ptr_select <= sel; status_load <= 1'b1; status_data <= 8'hA5;
    @(posedge clk);
    working_load <= 1'b0; ptr_load <= 1'b0; status_load <= 1'b0;
  endtask
  task automatic op(input imx_op_e c, input logic [1:0] m, input logic [5:0] k);
    @(posedge clk);
    op_valid <= 1'b1; op_code <= c; pointer_mode_code <= m; rel_offset <= k;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic t_modes;
    load(8'h55, 16'hFFFF, 1'b1);
    p = 16'hFFFF;
    for (int m = 0; m < 4; m++) begin
      op(IMX_OP_STORE_MODE, m[1:0], 6'h00);
      n = m[0] ? p - 16'h0001 : p + 16'h0001;
      `CHK("addr", m[1] ? p : n, mem_addr)
      `CHK("ptr1", n, file_select_pointer1)
      `CHK("data", 8'h55, mem_wdata)
      `CHK("status", 8'hA5, status_reg)
      p = n;
    end
    @(posedge clk);
    #1;
    `CHK("mem", 8'h55, u_mem.mem[16'h0000])
  endtask
  task automatic t_rel;
    load(8'h3C, 16'h0000, 1'b0);
    op(IMX_OP_STORE_REL, 2'h0, 6'h3F);
    `CHK("rel addr", 16'hFFFF, mem_addr)
    op(IMX_OP_STORE_REL, 2'h0, 6'h1F);
    `CHK("rel addr", 16'h001F, mem_addr)
    `CHK("ptr0", 16'h0000, file_select_pointer0)
  endtask
  task automatic t_opt;
    load(8'h4F, 16'h0020, 1'b0);
    op(IMX_OP_OPTION, 2'h0, 6'h00);
    `CHK("option", 8'h4F, option_reg)
    `CHK("working", 8'h4F, working_reg)
    op(IMX_OP_NOP, 2'h0, 6'h00);
    `CHK("pc", 1'b1, pc_advance)
    `CHK("wr", 1'b0, mem_wr)
    `CHK("ptr0", 16'h0020, file_select_pointer0)
  endtask
  task automatic t_reset;
    @(posedge clk);
    op_valid <= 1'b1; op_code <= IMX_OP_RESET; ri_flag_set <= 1'b1;
    @(posedge clk);
    op_code <= IMX_OP_OPTION; ri_flag_set <= 1'b0;
    #1;
    `CHK("flag", 1'b0, reset_instr_flag)
    `CHK("req", 1'b1, device_reset_req)
    `CHK("pc", 1'b0, pc_advance)
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    `CHK("option", 8'hFF, option_reg)
    `CHK("status", 8'h00, status_reg)
    `CHK("working", 8'h00, working_reg)
    `CHK("ptr1", 16'h0000, file_select_pointer1)
    @(posedge clk);
    #1;
    `CHK("req", 1'b0, device_reset_req)
    `CHK("pc", 1'b0, pc_advance)
    @(posedge clk);
    ri_flag_set <= 1'b1;
    @(posedge clk);
    ri_flag_set <= 1'b0;
    #1;
    `CHK("flag", 1'b1, reset_instr_flag)
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1; op_valid = 1'b0; op_code = IMX_OP_NONE; ptr_select = 1'b0;
    pointer_mode_code = 2'h0; rel_offset = 6'h00; working_load = 1'b0; working_data = 8'h00;
    ptr_load = 1'b0; ptr_load_data = 16'h0000; status_load = 1'b0; status_data = 8'h00;
    ri_flag_set = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("flag", 1'b1, reset_instr_flag)
    t_modes;
    t_rel;
    t_opt;
    t_reset;
    wrap_up;
  end
  // Whole run is under 100 cycles
  initial begin
    #50000;
    fail_count++;
    wrap_up;
  end
endmodule // indirect_move_misc_exec_test
